// File: src/fcb_flow_control_frame_buffer.sv
// ======================================================================
// Frame queue pointers over an address window
module fcb_q #(
	parameter int AW = 6
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Window
	input wire logic [AW-1:0] lo,
	input wire logic [AW-1:0] hi,
	input wire logic restart,
	// Write side
	input wire logic in_valid,
	input wire logic in_sof,
	input wire logic in_eof,
	output logic wr_en,
	output logic [AW-1:0] wr_addr,
	output logic ovf,
	output logic udf,
	// Read side
	input wire logic pop,
	input wire logic pop_eof,
	output logic [AW-1:0] rd_addr,
	output logic avail,
	output logic frame_rdy,
	output logic [AW-1:0] fill
);
	logic [AW-1:0] wptr;
	logic [AW-1:0] cptr;
	logic [AW-1:0] rptr;
	logic [AW:0] frames;
	logic inf;
	logic drop;
	logic ok_word;
	logic commit;

	function automatic logic [AW-1:0] nx(input logic [AW-1:0] p);
		nx = (p == hi) ? lo : AW'(p + 1'b1);
	endfunction

	// A new start discards an unfinished frame
	assign wr_addr = in_sof ? cptr : wptr;
	assign ok_word = in_valid & (in_sof | (inf & !drop));
	assign ovf = ok_word & (nx(wr_addr) == rptr);
	assign wr_en = ok_word & !ovf;
	assign udf = in_valid & ((in_sof & inf) | (!in_sof & in_eof & !inf & !drop));
	assign commit = wr_en & in_eof;
	assign rd_addr = rptr;
	// Only committed frames are readable
	assign avail = (rptr != cptr);
	assign frame_rdy = (frames != '0);
	assign fill = (wptr >= rptr) ? AW'(wptr - rptr)
		: AW'(wptr - rptr + hi - lo + 1'b1);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wptr <= '0;
			cptr <= '0;
			inf <= 1'b0;
			drop <= 1'b0;
		end else if (restart) begin
			wptr <= lo;
			cptr <= lo;
			inf <= 1'b0;
			drop <= 1'b0;
		end else if (wr_en) begin
			wptr <= nx(wr_addr);
			inf <= !in_eof;
			drop <= 1'b0;
			if (in_eof) begin
				cptr <= nx(wr_addr);
			end
		end else if (ovf) begin
			wptr <= cptr;
			inf <= 1'b0;
			drop <= !in_eof;
		end else if (in_valid & in_eof) begin
			drop <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rptr <= '0;
		end else if (restart) begin
			rptr <= lo;
		end else if (pop) begin
			rptr <= nx(rptr);
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			frames <= '0;
		end else if (restart) begin
			frames <= '0;
		end else if (commit & !(pop & pop_eof)) begin
			frames <= (AW+1)'(frames + 1'b1);
		end else if (!commit & pop & pop_eof) begin
			frames <= (AW+1)'(frames - 1'b1);
		end
	end
endmodule

// ======================================================================
// Read stage with parity check and frame abort
module fcb_rd (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// From storage
	input wire logic avail,
	input wire fcb_pkg::fcb_word_s word,
	input wire logic par,
	output logic pop,
	output logic done,
	output logic ecc,
	// Output stream
	input wire logic ready,
	output logic o_valid,
	output fcb_pkg::fcb_word_s o_word,
	output logic o_abort
);
	logic skip;
	logic bad;
	fcb_pkg::fcb_word_s cut;

	assign pop = avail & (!o_valid | ready);
	assign bad = ^{word, par};
	assign ecc = pop & bad & !skip;
	assign done = pop & word.eof;

	always_comb begin
		cut = word;
		cut.eof = 1'b1;
	end

	// Rest of an aborted frame is discarded
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			skip <= 1'b0;
		end else if (pop) begin
			skip <= (skip | bad) & !word.eof;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			o_valid <= 1'b0;
			o_word <= '0;
			o_abort <= 1'b0;
		end else if (pop & !skip) begin
			o_valid <= 1'b1;
			o_word <= bad ? cut : word;
			o_abort <= bad;
		end else if (ready) begin
			o_valid <= 1'b0;
			o_abort <= 1'b0;
		end
	end
endmodule

// ======================================================================
// Top
module fcb_flow_control_frame_buffer (
	// Clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// APB
	input wire logic [fcb_pkg::PADDR_W-1:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Egress from host
	input wire logic eg_in_valid,
	input wire fcb_pkg::fcb_word_s eg_in,
	// Egress to line
	input wire logic eg_out_ready,
	output logic eg_out_valid,
	output fcb_pkg::fcb_word_s eg_out,
	output logic eg_out_abort,
	// Line pause indication
	input wire logic line_pause_valid,
	input wire logic [15:0] line_pause_quanta,
	output logic host_xoff,
	// Ingress from line
	input wire logic ig_in_valid,
	input wire fcb_pkg::fcb_word_s ig_in,
	// Ingress to host
	input wire logic ig_out_ready,
	output logic ig_out_valid,
	output fcb_pkg::fcb_word_s ig_out,
	output logic ig_out_abort,
	// Interrupt
	output logic irq
);
	localparam int AW = fcb_pkg::EG_AW;
	localparam int WW = fcb_pkg::WW;

	logic rst_meta;
	logic rst_n;
	logic init;
	logic react_en;
	logic gen_en;
	logic merge_en;
	logic cq_en;
	logic ecc_test;
	logic [AW-1:0] cq_lo;
	logic [AW-1:0] cq_hi;
	logic [AW-1:0] dq_lo;
	logic [AW-1:0] dq_hi;
	logic [AW-1:0] xoff_thr;
	logic [AW-1:0] xon_thr;
	logic [fcb_pkg::NCNT-1:0] sticky;
	logic [fcb_pkg::NCNT-1:0] mask;
	logic [fcb_pkg::NCNT-1:0] ev;
	logic [31:0] cnt [fcb_pkg::NCNT];
	logic [WW:0] eg_mem [fcb_pkg::EG_WORDS];
	logic [WW:0] ig_mem [fcb_pkg::IG_WORDS];
	logic to_ctrl;
	logic c_wr, d_wr, i_wr;
	logic [AW-1:0] c_wa, d_wa, c_ra, d_ra, c_fill, d_fill;
	logic [fcb_pkg::IG_AW-1:0] i_wa, i_ra;
	logic c_av, d_av, i_av, c_fr, d_fr;
	logic eg_act, eg_sel, eg_pop, eg_done, eg_ecc;
	logic i_pop, i_done;
	logic [WW:0] eg_rd;
	logic [WW:0] ig_rd;
	fcb_pkg::fcb_pause_e pst;
	logic [15:0] pend_q;
	logic [15:0] ptimer;
	logic [fcb_pkg::QC_W-1:0] qcnt;
	logic thr_off;
	logic [AW:0] dsize;
	logic [AW:0] room_lim;
	logic [AW:0] eff_xoff;
	logic [31:0] rd_val;
	logic rd_hit;
	logic wr_acc;
	logic [3:0] cidx;

	// ==================================================================
	// Reset release
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rst_meta <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n <= rst_meta;
		end
	end

	// Pointers move into their windows one cycle after reset
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			init <= 1'b1;
		end else begin
			init <= 1'b0;
		end
	end

	// ==================================================================
	// Egress queues in one shared memory
	assign to_ctrl = cq_en & eg_in.ctrl;

	fcb_q #(.AW(AW)) u_cq (
		.clk(clk), .rst_n(rst_n),
		.lo(cq_lo), .hi(cq_hi),
		.restart(init | (wr_acc & (paddr == fcb_pkg::REG_CQ_WIN))),
		.in_valid(eg_in_valid & to_ctrl),
		.in_sof(eg_in.sof), .in_eof(eg_in.eof),
		.wr_en(c_wr), .wr_addr(c_wa),
		.ovf(ev[fcb_pkg::EV_EC_OVF]), .udf(ev[fcb_pkg::EV_EC_UDF]),
		.pop(eg_pop & eg_sel), .pop_eof(eg_done),
		.rd_addr(c_ra), .avail(c_av), .frame_rdy(c_fr), .fill(c_fill)
	);

	// Special words travel as one-word frames among the data
	fcb_q #(.AW(AW)) u_dq (
		.clk(clk), .rst_n(rst_n),
		.lo(dq_lo), .hi(dq_hi),
		.restart(init | (wr_acc & (paddr == fcb_pkg::REG_DQ_WIN))),
		.in_valid(eg_in_valid & !to_ctrl),
		.in_sof(eg_in.sof), .in_eof(eg_in.eof),
		.wr_en(d_wr), .wr_addr(d_wa),
		.ovf(ev[fcb_pkg::EV_ED_OVF]), .udf(ev[fcb_pkg::EV_ED_UDF]),
		.pop(eg_pop & !eg_sel), .pop_eof(eg_done),
		.rd_addr(d_ra), .avail(d_av), .frame_rdy(d_fr), .fill(d_fill)
	);

	// Storage of four MTUs
	always_ff @(posedge clk) begin
		if (c_wr | d_wr) begin
			eg_mem[c_wr ? c_wa : d_wa] <= {eg_in, ^eg_in ^ ecc_test};
		end
	end

	assign eg_rd = eg_mem[eg_sel ? c_ra : d_ra];

	// ==================================================================
	// Egress scheduler, chooses only between frames
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			eg_act <= 1'b0;
			eg_sel <= 1'b0;
		end else if (!eg_act) begin
			if (cq_en & c_fr) begin
				eg_act <= 1'b1;
				eg_sel <= 1'b1;
			end else if (d_fr & (pst == fcb_pkg::P_RUN)) begin
				eg_act <= 1'b1;
				eg_sel <= 1'b0;
			end
		end else if (eg_done) begin
			eg_act <= 1'b0;
		end
	end

	fcb_rd u_eg_rd (
		.clk(clk), .rst_n(rst_n),
		.avail(eg_act & (eg_sel ? c_av : d_av)),
		.word(fcb_pkg::fcb_word_s'(eg_rd[WW:1])), .par(eg_rd[0]),
		.pop(eg_pop), .done(eg_done), .ecc(eg_ecc),
		.ready(eg_out_ready), .o_valid(eg_out_valid),
		.o_word(eg_out), .o_abort(eg_out_abort)
	);

	assign ev[fcb_pkg::EV_EC_ECC] = eg_ecc & eg_sel;
	assign ev[fcb_pkg::EV_ED_ECC] = eg_ecc & !eg_sel;

	// ==================================================================
	// Line pause reaction
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pst <= fcb_pkg::P_RUN;
			pend_q <= '0;
			ptimer <= '0;
			qcnt <= '0;
		end else if (!react_en) begin
			pst <= fcb_pkg::P_RUN;
		end else begin
			unique case (pst)
				fcb_pkg::P_RUN: begin
					if (line_pause_valid & (line_pause_quanta != '0)) begin
						pst <= fcb_pkg::P_PEND;
						pend_q <= line_pause_quanta;
					end
				end
				fcb_pkg::P_PEND: begin
					if (line_pause_valid) begin
						pend_q <= line_pause_quanta;
						if (line_pause_quanta == '0) begin
							pst <= fcb_pkg::P_RUN;
						end
					end else if (!eg_act) begin
						pst <= fcb_pkg::P_HOLD;
						ptimer <= pend_q;
						qcnt <= '0;
					end
				end
				fcb_pkg::P_HOLD: begin
					if (line_pause_valid) begin
						ptimer <= line_pause_quanta;
						qcnt <= '0;
						if (line_pause_quanta == '0) begin
							pst <= fcb_pkg::P_RUN;
						end
					end else if (qcnt == fcb_pkg::QC_W'(fcb_pkg::QUANTUM_CYC - 1)) begin
						qcnt <= '0;
						ptimer <= 16'(ptimer - 1'b1);
						if (ptimer <= 16'h0001) begin
							pst <= fcb_pkg::P_RUN;
						end
					end else begin
						qcnt <= fcb_pkg::QC_W'(qcnt + 1'b1);
					end
				end
				default: begin
					pst <= fcb_pkg::P_RUN;
				end
			endcase
		end
	end

	// ==================================================================
	// Threshold XOFF/XON toward the host transmitter
	assign dsize = (AW+1)'(dq_hi - dq_lo) + 1'b1;
	assign room_lim = (dsize > (AW+1)'(fcb_pkg::MTU_WORDS))
		? (AW+1)'(dsize - (AW+1)'(fcb_pkg::MTU_WORDS)) : '0;
	// Threshold clamped so one jumbo still fits after XOFF
	assign eff_xoff = ({1'b0, xoff_thr} > room_lim) ? room_lim
		: {1'b0, xoff_thr};

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			thr_off <= 1'b0;
		end else if ({1'b0, d_fill} >= eff_xoff) begin
			thr_off <= 1'b1;
		end else if (d_fill <= xon_thr) begin
			thr_off <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			host_xoff <= 1'b0;
		end else begin
			host_xoff <= (gen_en & thr_off)
				| (merge_en & (pst != fcb_pkg::P_RUN));
		end
	end

	// ==================================================================
	// Ingress buffer
	fcb_q #(.AW(fcb_pkg::IG_AW)) u_iq (
		.clk(clk), .rst_n(rst_n),
		.lo('0), .hi(fcb_pkg::IG_AW'(fcb_pkg::IG_WORDS - 1)),
		.restart(1'b0),
		.in_valid(ig_in_valid),
		.in_sof(ig_in.sof), .in_eof(ig_in.eof),
		.wr_en(i_wr), .wr_addr(i_wa),
		.ovf(ev[fcb_pkg::EV_IG_OVF]), .udf(ev[fcb_pkg::EV_IG_UDF]),
		.pop(i_pop), .pop_eof(i_done),
		.rd_addr(i_ra), .avail(i_av), .frame_rdy(), .fill()
	);

	always_ff @(posedge clk) begin
		if (i_wr) begin
			ig_mem[i_wa] <= {ig_in, ^ig_in ^ ecc_test};
		end
	end

	assign ig_rd = ig_mem[i_ra];

	fcb_rd u_ig_rd (
		.clk(clk), .rst_n(rst_n),
		.avail(i_av),
		.word(fcb_pkg::fcb_word_s'(ig_rd[WW:1])), .par(ig_rd[0]),
		.pop(i_pop), .done(i_done), .ecc(ev[fcb_pkg::EV_IG_ECC]),
		.ready(ig_out_ready), .o_valid(ig_out_valid),
		.o_word(ig_out), .o_abort(ig_out_abort)
	);

	// ==================================================================
	// APB slave, zero wait states
	assign pready = 1'b1;
	assign wr_acc = psel & penable & pwrite;
	assign pslverr = psel & penable & !rd_hit;
	assign cidx = 4'((paddr - fcb_pkg::REG_CNT0) >> 2);

	always_comb begin
		rd_hit = 1'b1;
		rd_val = '0;
		case (paddr)
			fcb_pkg::REG_CTRL: rd_val[4:0] = {ecc_test, cq_en, merge_en,
				gen_en, react_en};
			fcb_pkg::REG_CQ_WIN: rd_val[13:0] = {cq_hi, 2'b00, cq_lo};
			fcb_pkg::REG_DQ_WIN: rd_val[13:0] = {dq_hi, 2'b00, dq_lo};
			fcb_pkg::REG_THR: rd_val[13:0] = {xon_thr, 2'b00, xoff_thr};
			fcb_pkg::REG_STATUS: rd_val[3:0] = {host_xoff, thr_off,
				pst == fcb_pkg::P_PEND, pst == fcb_pkg::P_HOLD};
			fcb_pkg::REG_STICKY: rd_val[fcb_pkg::NCNT-1:0] = sticky;
			fcb_pkg::REG_MASK: rd_val[fcb_pkg::NCNT-1:0] = mask;
			default: begin
				if ((paddr >= fcb_pkg::REG_CNT0) & (paddr <= fcb_pkg::REG_CNT_LAST)
						& (paddr[1:0] == 2'b00)) begin
					rd_val = cnt[cidx];
				end else begin
					rd_hit = 1'b0;
				end
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			prdata <= '0;
		end else if (psel & !penable & !pwrite) begin
			prdata <= rd_val;
		end
	end

	// Advanced mode is purely a software setting of these bits
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			{ecc_test, cq_en, merge_en, gen_en, react_en} <= fcb_pkg::RST_CTRL[4:0];
		end else if (wr_acc & (paddr == fcb_pkg::REG_CTRL)) begin
			react_en <= pwdata[fcb_pkg::CTRL_REACT];
			gen_en <= pwdata[fcb_pkg::CTRL_GEN];
			merge_en <= pwdata[fcb_pkg::CTRL_MERGE];
			cq_en <= pwdata[fcb_pkg::CTRL_CQ_EN];
			ecc_test <= pwdata[fcb_pkg::CTRL_ECC_TEST];
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cq_lo <= fcb_pkg::RST_CQ_WIN[fcb_pkg::WIN_START_LSB +: AW];
			cq_hi <= fcb_pkg::RST_CQ_WIN[fcb_pkg::WIN_END_LSB +: AW];
			dq_lo <= fcb_pkg::RST_DQ_WIN[fcb_pkg::WIN_START_LSB +: AW];
			dq_hi <= fcb_pkg::RST_DQ_WIN[fcb_pkg::WIN_END_LSB +: AW];
			xoff_thr <= fcb_pkg::RST_THR[fcb_pkg::THR_XOFF_LSB +: AW];
			xon_thr <= fcb_pkg::RST_THR[fcb_pkg::THR_XON_LSB +: AW];
		end else if (wr_acc & (paddr == fcb_pkg::REG_CQ_WIN)) begin
			cq_lo <= pwdata[fcb_pkg::WIN_START_LSB +: AW];
			cq_hi <= pwdata[fcb_pkg::WIN_END_LSB +: AW];
		end else if (wr_acc & (paddr == fcb_pkg::REG_DQ_WIN)) begin
			dq_lo <= pwdata[fcb_pkg::WIN_START_LSB +: AW];
			dq_hi <= pwdata[fcb_pkg::WIN_END_LSB +: AW];
		end else if (wr_acc & (paddr == fcb_pkg::REG_THR)) begin
			xoff_thr <= pwdata[fcb_pkg::THR_XOFF_LSB +: AW];
			xon_thr <= pwdata[fcb_pkg::THR_XON_LSB +: AW];
		end
	end

	// ==================================================================
	// Sticky events, mask and drop counters
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sticky <= '0;
		end else if (wr_acc & (paddr == fcb_pkg::REG_STICKY)) begin
			sticky <= (sticky & ~pwdata[fcb_pkg::NCNT-1:0]) | ev;
		end else begin
			sticky <= sticky | ev;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mask <= '0;
		end else if (wr_acc & (paddr == fcb_pkg::REG_MASK)) begin
			mask <= pwdata[fcb_pkg::NCNT-1:0];
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			irq <= 1'b0;
		end else begin
			irq <= |(sticky & mask);
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < fcb_pkg::NCNT; i++) begin
				cnt[i] <= '0;
			end
		end else begin
			for (int i = 0; i < fcb_pkg::NCNT; i++) begin
				cnt[i] <= cnt[i] + {31'h0000_0000, ev[i]};
			end
		end
	end
endmodule

// File: src/fcb_pkg.sv
// Overview of operation
// - Line pause is entered only at the next egress frame boundary.
// - Pause timer lives here and starts only once paused.
// - While paused no data frame starts toward line; host input is still accepted.
// - With merging on, line pause raises XOFF toward the host transmitter.
// - XOFF on fill reaching the XOFF threshold, XON at the XON threshold.
// - After XOFF at least one jumbo frame of room remains.
// - Reaction enable gates line pause reaction and timer upkeep.
// - Generation enable gates threshold XON/XOFF toward the host.
// - Merge bit ORs pause state into the request; cleared, thresholds only.
// - Separate control and data queues; control relayed at next boundary.
// - Strict priority: control queue before data queue.
// - Control frames go to line even while paused.
// - Control queue enable decides whether the control queue is used.
// - Egress memory split by programmable start and end per queue.
// - Egress storage is four times the maximum transfer unit.
// - Fault and low-power control words pass in-band both directions.
// - Drop counters are 32 bits and wrap to zero.
// - Egress control queue overflow and underflow drops counted apart.
// - Egress data queue overflow and underflow drops counted apart.
// - Ingress overflow and underflow drops counted apart.
// - ECC-failed frames aborted, counted per control, data, ingress.
// - Pause values are in quanta of 512 bit times.
package fcb_pkg;
	// ==================================================================
	// Sizes
	localparam int PADDR_W = 8;
	localparam int MTU_WORDS = 16;
	localparam int EG_WORDS = 4 * MTU_WORDS;
	localparam int EG_AW = $clog2(EG_WORDS);
	localparam int IG_WORDS = 16;
	localparam int IG_AW = $clog2(IG_WORDS);
	localparam int NCNT = 9;
	// ==================================================================
	// Timing
	localparam int QUANTUM_BITS = 512;
	localparam int BIT_TIME_PS = 1000;
	localparam int CLK_PS = 8000;
	localparam int QUANTUM_CYC = (QUANTUM_BITS * BIT_TIME_PS + CLK_PS - 1)
		/ CLK_PS;
	localparam int QC_W = $clog2(QUANTUM_CYC);
	// ==================================================================
	// Register offsets
	localparam logic [PADDR_W-1:0] REG_CTRL = 8'h00;
	localparam logic [PADDR_W-1:0] REG_CQ_WIN = 8'h04;
	localparam logic [PADDR_W-1:0] REG_DQ_WIN = 8'h08;
	localparam logic [PADDR_W-1:0] REG_THR = 8'h0C;
	localparam logic [PADDR_W-1:0] REG_STATUS = 8'h10;
	localparam logic [PADDR_W-1:0] REG_STICKY = 8'h14;
	localparam logic [PADDR_W-1:0] REG_MASK = 8'h18;
	localparam logic [PADDR_W-1:0] REG_CNT0 = 8'h20;
	localparam logic [PADDR_W-1:0] REG_CNT_LAST = 8'h40;
	// ==================================================================
	// Field positions
	localparam int CTRL_REACT = 0;
	localparam int CTRL_GEN = 1;
	localparam int CTRL_MERGE = 2;
	localparam int CTRL_CQ_EN = 3;
	localparam int CTRL_ECC_TEST = 4;
	localparam int WIN_START_LSB = 0;
	localparam int WIN_END_LSB = 8;
	localparam int THR_XOFF_LSB = 0;
	localparam int THR_XON_LSB = 8;
	// Event and counter order
	localparam int EV_EC_OVF = 0;
	localparam int EV_EC_UDF = 1;
	localparam int EV_EC_ECC = 2;
	localparam int EV_ED_OVF = 3;
	localparam int EV_ED_UDF = 4;
	localparam int EV_ED_ECC = 5;
	localparam int EV_IG_OVF = 6;
	localparam int EV_IG_UDF = 7;
	localparam int EV_IG_ECC = 8;
	// ==================================================================
	// Reset values
	localparam logic [31:0] RST_CTRL = 32'h0000_000F;
	localparam logic [31:0] RST_CQ_WIN = 32'h0000_0F00;
	localparam logic [31:0] RST_DQ_WIN = 32'h0000_3F10;
	localparam logic [31:0] RST_THR = 32'h0000_1020;
	// ==================================================================
	// Types
	typedef struct packed {
		logic [31:0] data;
		logic sof;
		logic eof;
		logic ctrl;
		logic special;
	} fcb_word_s;
	localparam int WW = $bits(fcb_word_s);
	typedef enum logic [2:0] {
		P_RUN = 3'b001,
		P_PEND = 3'b010,
		P_HOLD = 3'b100
	} fcb_pause_e;
endpackage

// File: test/fcb_assertions.sv
module fcb_checker (
	// Clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// APB
	input wire logic [fcb_pkg::PADDR_W-1:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Streams
	input wire logic eg_out_ready,
	input wire logic eg_out_valid,
	input wire fcb_pkg::fcb_word_s eg_out,
	input wire logic eg_out_abort,
	input wire logic ig_out_ready,
	input wire logic ig_out_valid,
	input wire fcb_pkg::fcb_word_s ig_out,
	input wire logic ig_out_abort,
	input wire logic host_xoff,
	input wire logic irq
);
	timeunit 1ns;
	timeprecision 1ps;
	logic acc;
	logic mapped;
	assign acc = psel && penable;
	assign mapped = paddr[1:0] == 2'b00 && (paddr <= fcb_pkg::REG_MASK
		|| (paddr >= fcb_pkg::REG_CNT0 && paddr <= fcb_pkg::REG_CNT_LAST));
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	a_pready_high: assert property (pready)
		else $error("pready low");
	a_slverr_map: assert property (acc |-> pslverr == !mapped)
		else $error("pslverr wrong for address");
	a_slverr_idle: assert property (!acc |-> !pslverr)
		else $error("pslverr outside access");
	a_prdata_hold: assert property (acc |=> $stable(prdata))
		else $error("prdata moved after access");
	a_eg_hold: assert property (eg_out_valid && !eg_out_ready
		|=> eg_out_valid && $stable(eg_out))
		else $error("egress word not held");
	a_ig_hold: assert property (ig_out_valid && !ig_out_ready
		|=> ig_out_valid && $stable(ig_out))
		else $error("ingress word not held");
	a_eg_abort_eof: assert property (
		eg_out_abort |-> eg_out_valid && eg_out.eof)
		else $error("egress abort not on last word");
	a_ig_abort_eof: assert property (
		ig_out_abort |-> ig_out_valid && ig_out.eof)
		else $error("ingress abort not on last word");
	a_reset_quiet: assert property (disable iff (1'b0) !arst_n
		|-> !eg_out_valid && !ig_out_valid && !irq && !host_xoff)
		else $error("output active in reset");
endmodule
bind fcb_flow_control_frame_buffer fcb_checker u_chk (.clk, .arst_n,
	.paddr, .psel, .penable, .prdata, .pready, .pslverr, .eg_out_ready,
	.eg_out_valid, .eg_out, .eg_out_abort, .ig_out_ready, .ig_out_valid,
	.ig_out, .ig_out_abort, .host_xoff, .irq);

// File: test/fcb_line_model.sv
module fcb_line_model (
	// Clock and control
	input wire logic clk,
	input wire logic stall,
	// Egress toward line
	input wire logic eg_out_valid,
	input wire fcb_pkg::fcb_word_s eg_out,
	input wire logic eg_out_abort,
	output logic eg_out_ready
);
	timeunit 1ns;
	timeprecision 1ps;
	fcb_pkg::fcb_word_s got[$];
	int aborts = 0;
	// Line sink; may stall for any length
	always @(posedge clk) begin
		if (eg_out_valid && eg_out_ready) begin
			got.push_back(eg_out);
			if (eg_out_abort)
				aborts++;
		end
		eg_out_ready <= !stall;
	end
endmodule

// File: test/testbench.sv
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic arst_n, psel, penable, pwrite, pready, pslverr, err, stall;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic eg_in_valid, eg_out_ready, eg_out_valid, eg_out_abort;
	logic line_pause_valid, host_xoff, ig_in_valid, ig_out_valid;
	logic ig_out_abort, irq;
	logic ig_out_ready = 1'b1;
	logic [15:0] line_pause_quanta;
	fcb_pkg::fcb_word_s eg_in, eg_out, ig_in, ig_out;
	int bad_count = 0;
	int tests_run = 0;
	int cyc = 0;
	always #4 clk = ~clk;
	fcb_flow_control_frame_buffer DUT (.clk, .arst_n, .paddr, .psel,
		.penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
		.eg_in_valid, .eg_in, .eg_out_ready, .eg_out_valid, .eg_out,
		.eg_out_abort, .line_pause_valid, .line_pause_quanta, .host_xoff,
		.ig_in_valid, .ig_in, .ig_out_ready, .ig_out_valid, .ig_out,
		.ig_out_abort, .irq);
	fcb_line_model line (.clk, .stall, .eg_out_valid, .eg_out,
		.eg_out_abort, .eg_out_ready);
	// ====
	// Shared tasks
	task automatic complete_run;
		$display("bad_count=%0d tests_run=%0d", bad_count, tests_run);
		if (bad_count == 0 && tests_run > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		tests_run++;
		if (g !== e) begin
			bad_count++;
			$display("Error %0t: got %h want %h", $time, g, e);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1)
			@(posedge clk);
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0000_0000);
		chk(q, e);
	endtask
	task automatic send(input logic ig, s, c, sp, input int n);
		fcb_pkg::fcb_word_s w;
		for (int i = 0; i < n; i++) begin
			w = '{32'h0000_00A0 + i, s && i == 0, i == n - 1, c, sp};
			ig_in <= w;
			eg_in <= w;
			ig_in_valid <= ig;
			eg_in_valid <= !ig;
			@(posedge clk);
		end
		eg_in_valid <= 1'b0;
		ig_in_valid <= 1'b0;
		@(posedge clk);
	endtask
	task automatic wait_got(input int n);
		for (int i = 0; i < 300 && line.got.size() < n; i++)
			@(posedge clk);
		chk(line.got.size(), n);
	endtask
	// ====
	// Scenarios
	task automatic t_regs;
		rd(fcb_pkg::REG_CTRL, 32'h0000_000F);
		rd(fcb_pkg::REG_CQ_WIN, 32'h0000_0F00);
		rd(fcb_pkg::REG_DQ_WIN, 32'h0000_3F10);
		rd(fcb_pkg::REG_THR, 32'h0000_1020);
		rd(8'h1C, 32'h0000_0000);
		chk(err, 1);
		rd(fcb_pkg::REG_CNT0, 32'h0000_0000);
	endtask
	task automatic t_pause;
		line_pause_valid <= 1'b1;
		line_pause_quanta <= 16'h0001;
		@(posedge clk);
		line_pause_valid <= 1'b0;
		send(0, 1, 0, 0, 2);
		send(0, 1, 1, 0, 1);
		repeat (25) @(posedge clk);
		chk(line.got.size(), 1);
		chk(line.got[0].ctrl, 1);
		chk(host_xoff, 1);
		rd(fcb_pkg::REG_STATUS, 32'h0000_0009);
		wait_got(3);
		chk(line.got[1].data, 32'h0000_00A0);
		repeat (2) @(posedge clk);
		chk(host_xoff, 0);
		// Zero-quanta pulse ends a running pause
		line_pause_valid <= 1'b1;
		line_pause_quanta <= 16'h0005;
		@(posedge clk);
		line_pause_valid <= 1'b0;
		repeat (3) @(posedge clk);
		rd(fcb_pkg::REG_STATUS, 32'h0000_0009);
		line_pause_valid <= 1'b1;
		line_pause_quanta <= 16'h0000;
		@(posedge clk);
		line_pause_valid <= 1'b0;
		repeat (2) @(posedge clk);
		rd(fcb_pkg::REG_STATUS, 32'h0000_0000);
	endtask
	task automatic t_udf;
		send(0, 0, 0, 0, 1);
		rd(fcb_pkg::REG_CNT0 + 8'h10, 32'h0000_0001);
		rd(fcb_pkg::REG_STICKY, 32'h0000_0010);
		apb(1'b1, fcb_pkg::REG_MASK, 32'h0000_0010);
		repeat (2) @(posedge clk);
		chk(irq, 1);
		apb(1'b1, fcb_pkg::REG_STICKY, 32'h0000_0010);
		repeat (2) @(posedge clk);
		chk(irq, 0);
	endtask
	task automatic t_ecc;
		line.got.delete();
		apb(1'b1, fcb_pkg::REG_CTRL, 32'h0000_001F);
		send(0, 1, 0, 0, 2);
		// Aborted frame leaves as one cut word
		wait_got(1);
		chk(line.got[0].eof, 1);
		chk(line.aborts, 1);
		rd(fcb_pkg::REG_CNT0 + 8'h14, 32'h0000_0001);
		apb(1'b1, fcb_pkg::REG_CTRL, 32'h0000_000F);
	endtask
	task automatic t_thr(input logic [31:0] ctl, input logic e);
		line.got.delete();
		apb(1'b1, fcb_pkg::REG_CTRL, ctl);
		apb(1'b1, fcb_pkg::REG_THR, 32'h0000_0104);
		stall <= 1'b1;
		send(0, 1, 0, 0, 6);
		chk(host_xoff, e);
		stall <= 1'b0;
		wait_got(6);
		repeat (3) @(posedge clk);
		chk(host_xoff, 0);
	endtask
	task automatic t_ing;
		send(1, 1, 0, 1, 1);
		for (int i = 0; i < 20 && ig_out_valid !== 1'b1; i++)
			@(posedge clk);
		chk(ig_out.special, 1);
		chk(ig_out_abort, 0);
		// Frame longer than the ingress ring is dropped once
		send(1, 1, 0, 0, 17);
		rd(fcb_pkg::REG_CNT0 + 8'h18, 32'h0000_0001);
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			bad_count++;
			complete_run();
		end
	end
	initial begin
		{arst_n, psel, penable, pwrite, stall} = '0;
		{eg_in_valid, ig_in_valid, line_pause_valid} = '0;
		{paddr, pwdata, line_pause_quanta} = '0;
		eg_in = '0;
		ig_in = '0;
		repeat (10) @(posedge clk);
		arst_n <= 1'b1;
		repeat (5) @(posedge clk);
		t_regs();
		t_pause();
		t_udf();
		t_ecc();
		t_thr(32'h0000_000F, 1'b1);
		t_thr(32'h0000_000D, 1'b0);
		t_thr(32'h0000_0002, 1'b1);
		t_ing();
		complete_run();
	end
endmodule
